// *** logic/ccgow_top.sv ***
`timescale 1ns/1ns
// How it works
// - mode pins latched once at reset release; kept until next reset
// - pll codes multiply input by 4, 3, 8, 5, 10 or 16
// - code 001 divides the input clock by two
// - prescaler phases each last one input period
// - code 011 keeps pll out of the cpu path, bypasses amplifier, drives cpu directly
// - direct drive cpu clock copies the input, duty cycle included
// - non-pll modes run free pll for watchdog unless disable bit set
// - watchdog on after reset; bit 4 of config register disables it
// - watchdog counter counts pll cycles, cleared on input transitions
// - sixteen pll cycles without input transition means clock failure
// - on failure cpu clock moves to free pll clock, flag raised
// - failover held until hardware or bidirectional reset
// - watchdog disabled before a failure keeps cpu on external clock, pll off
// - all other codes enable pll, cpu equals input times factor
// - pll resyncs every factor input rising edges, smoothly
// - pll chain input divider, multiplier, output divider per code
module ccgow_top
  import ccgow_pkg::*;
#(
  parameter int FREE_DIV = 10,
  parameter int PER_W    = 16
) (
  // clock, reset, enable
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_clk_en,
  input  wire logic        i_bidir_rst,
  // pins
  input  wire logic [2:0]  i_clock_mode_select_pins,
  input  wire logic        i_crystal_input_pin,
  // clock outputs
  output logic             o_cpu_clk,
  output logic             o_pll_free_clk,
  output logic             o_pll_enable,
  output logic             o_osc_amp_bypass,
  output logic             o_osc_wd_irq,
  // pll chain settings
  output logic [6:0]       o_pll_in_div,
  output logic [6:0]       o_pll_mult,
  output logic [6:0]       o_pll_out_div,
  // avalon-mm slave
  input  wire logic [1:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest
);

  typedef enum {
    CCGOW_ST_WAIT,
    CCGOW_ST_PLL,
    CCGOW_ST_PRESC,
    CCGOW_ST_DIRECT,
    CCGOW_ST_FAILOVER
  } ccgow_src_e;

  function automatic logic [4:0] mode_factor(input logic [2:0] m);
    case (m)
      MODE_X4:       mode_factor = FACT_X4;
      MODE_X3:       mode_factor = FACT_X3;
      MODE_X8:       mode_factor = FACT_X8;
      MODE_X5:       mode_factor = FACT_X5;
      MODE_X10:      mode_factor = FACT_X10;
      MODE_X16:      mode_factor = FACT_X16;
      default:       mode_factor = FACT_ONE;
    endcase
  endfunction : mode_factor

  function automatic logic is_pll_mode(input logic [2:0] m);
    is_pll_mode = (m != MODE_DIRECT) && (m != MODE_PRESCALE);
  endfunction : is_pll_mode

  logic [2:0]       mode_ff;
  logic             strap_ok_ff;
  ccgow_src_e       src_ff;
  ccgow_src_e       nxt_src;
  logic             xtal_ff;
  logic             xtal_prev_ff;
  logic             xtal_edge;
  logic             xtal_rise;
  logic [31:0]      sys_cfg_ff;
  logic             wd_disable;
  logic             wd_fail;
  logic             pll_mode;
  logic             free_run;
  logic [7:0]       free_cnt_ff;
  logic             pll_tick;
  logic             free_clk_ff;
  logic             presc_clk_ff;
  logic [4:0]       factor;
  logic [4:0]       edge_cnt_ff;
  logic [PER_W-1:0] win_cnt_ff;
  logic [PER_W-1:0] period_ff;
  logic [PER_W:0]   acc_ff;
  logic [PER_W:0]   nxt_acc;
  logic [PER_W:0]   step;
  logic             nco_clk_ff;
  logic             cpu_clk_ff;
  logic             irq_ff;
  logic             ack_ff;
  logic [31:0]      rdata_ff;
  logic             access;
  logic             wr_take;
  logic             irq_clr;

  localparam logic [7:0] FREE_LAST = 8'(FREE_DIV - 1);

  // strap catch: sampled by the first enabled edge after release
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_ff     <= MODE_X4;
      strap_ok_ff <= 1'b0;
    end else if (i_clk_en) begin
      if (i_bidir_rst) begin
        strap_ok_ff <= 1'b0;
      end else if (!strap_ok_ff) begin
        mode_ff     <= i_clock_mode_select_pins;
        strap_ok_ff <= 1'b1;
      end
    end
  end

  assign pll_mode = is_pll_mode(mode_ff);
  assign factor   = mode_factor(mode_ff);

  // input sampling, synchronous by contract
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      xtal_ff      <= 1'b0;
      xtal_prev_ff <= 1'b0;
    end else if (i_clk_en) begin
      xtal_ff      <= i_crystal_input_pin;
      xtal_prev_ff <= xtal_ff;
    end
  end

  assign xtal_edge = xtal_ff ^ xtal_prev_ff;
  assign xtal_rise = xtal_ff & ~xtal_prev_ff;

  // clock source selection
  always_comb begin
    nxt_src = src_ff;
    case (src_ff)
      CCGOW_ST_WAIT: begin
        if (strap_ok_ff) begin
          if (pll_mode) begin
            nxt_src = CCGOW_ST_PLL;
          end else if (mode_ff == MODE_PRESCALE) begin
            nxt_src = CCGOW_ST_PRESC;
          end else begin
            nxt_src = CCGOW_ST_DIRECT;
          end
        end
      end
      CCGOW_ST_PRESC,
      CCGOW_ST_DIRECT: begin
        if (wd_fail) begin
          nxt_src = CCGOW_ST_FAILOVER;
        end
      end
      CCGOW_ST_PLL,
      CCGOW_ST_FAILOVER: nxt_src = src_ff;
      default: nxt_src = CCGOW_ST_WAIT;
    endcase
    if (!strap_ok_ff) begin
      nxt_src = CCGOW_ST_WAIT;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      src_ff <= CCGOW_ST_WAIT;
    end else if (i_clk_en) begin
      src_ff <= i_bidir_rst ? CCGOW_ST_WAIT : nxt_src;
    end
  end

  // config register; watchdog enabled after reset
  assign wd_disable = sys_cfg_ff[BIT_WD_DISABLE];

  // free pll runs for the watchdog, or as backup after failover
  assign free_run = strap_ok_ff && !pll_mode
                    && (!wd_disable || src_ff == CCGOW_ST_FAILOVER);

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      free_cnt_ff <= 8'h00;
      free_clk_ff <= 1'b0;
    end else if (i_clk_en) begin
      if (!free_run) begin
        free_cnt_ff <= 8'h00;
        free_clk_ff <= 1'b0;
      end else if (free_cnt_ff == FREE_LAST) begin
        free_cnt_ff <= 8'h00;
        free_clk_ff <= ~free_clk_ff;
      end else begin
        free_cnt_ff <= free_cnt_ff + 8'h01;
      end
    end
  end

  // one watchdog count per full free pll period
  assign pll_tick = free_run && free_clk_ff && free_cnt_ff == FREE_LAST;

  ccgow_osc_watchdog #(
    .CNT_W (5),
    .OVF   (OSC_WD_OVF)
  ) u_osc_wd (
    .i_ref_clk   (i_ref_clk),
    .i_rst_b     (i_rst_b),
    .i_clk_en    (i_clk_en),
    .i_restart   (i_bidir_rst),
    .i_enable    (!wd_disable && (src_ff == CCGOW_ST_PRESC
                  || src_ff == CCGOW_ST_DIRECT)),
    .i_pll_tick  (pll_tick),
    .i_xtal_edge (xtal_edge),
    .o_fail      (wd_fail)
  );

  // prescaler toggles on each input rise: each phase one input period
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      presc_clk_ff <= 1'b0;
    end else if (i_clk_en) begin
      if (xtal_rise) begin
        presc_clk_ff <= ~presc_clk_ff;
      end
    end
  end

  // pll model: period of factor input cycles measured in ref clocks
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      edge_cnt_ff <= 5'h00;
      win_cnt_ff  <= '0;
      period_ff   <= '0;
    end else if (i_clk_en) begin
      if (src_ff != CCGOW_ST_PLL) begin
        edge_cnt_ff <= 5'h00;
        win_cnt_ff  <= '0;
      end else if (xtal_rise && edge_cnt_ff == factor - 5'h01) begin
        edge_cnt_ff <= 5'h00;
        win_cnt_ff  <= PER_W'(1);
        period_ff   <= win_cnt_ff + PER_W'(1);
      end else begin
        if (xtal_rise) begin
          edge_cnt_ff <= edge_cnt_ff + 5'h01;
        end
        if (win_cnt_ff != '1) begin
          win_cnt_ff <= win_cnt_ff + PER_W'(1);
        end
      end
    end
  end

  // 2*f*f toggles per window of f input periods; acc kept across resync
  // so the rate slews instead of jumping
  assign step = (PER_W+1)'(factor) * (PER_W+1)'(factor) * (PER_W+1)'(2);

  always_comb begin
    nxt_acc = acc_ff + step;
    if (nxt_acc >= {1'b0, period_ff}) begin
      nxt_acc = nxt_acc - {1'b0, period_ff};
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc_ff     <= '0;
      nco_clk_ff <= 1'b0;
    end else if (i_clk_en) begin
      if (src_ff != CCGOW_ST_PLL || period_ff == '0) begin
        acc_ff     <= '0;
        nco_clk_ff <= 1'b0;
      end else begin
        acc_ff <= nxt_acc;
        if (acc_ff + step >= {1'b0, period_ff}) begin
          nco_clk_ff <= ~nco_clk_ff;
        end
      end
    end
  end

  // cpu clock mux
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cpu_clk_ff <= 1'b0;
    end else if (i_clk_en) begin
      case (src_ff)
        CCGOW_ST_PLL:      cpu_clk_ff <= nco_clk_ff;
        CCGOW_ST_PRESC:    cpu_clk_ff <= presc_clk_ff;
        CCGOW_ST_DIRECT:   cpu_clk_ff <= xtal_ff;
        CCGOW_ST_FAILOVER: cpu_clk_ff <= free_clk_ff;
        default:           cpu_clk_ff <= 1'b0;
      endcase
    end
  end

  assign o_cpu_clk        = cpu_clk_ff;
  assign o_pll_free_clk   = free_clk_ff;
  assign o_pll_enable     = (strap_ok_ff && pll_mode) || free_run;
  assign o_osc_amp_bypass = strap_ok_ff && mode_ff == MODE_DIRECT;
  assign o_osc_wd_irq     = irq_ff;

  // divider chain per code
  always_comb begin
    o_pll_in_div  = DIV_NONE;
    o_pll_mult    = DIV_NONE;
    o_pll_out_div = DIV_NONE;
    if (strap_ok_ff) begin
      case (mode_ff)
        MODE_X4: begin
          o_pll_in_div  = IN_DIV_4;
          o_pll_mult    = MULT_64;
          o_pll_out_div = OUT_DIV_4;
        end
        MODE_X3: begin
          o_pll_in_div  = IN_DIV_4;
          o_pll_mult    = MULT_48;
          o_pll_out_div = OUT_DIV_4;
        end
        MODE_X8: begin
          o_pll_in_div  = IN_DIV_4;
          o_pll_mult    = MULT_64;
          o_pll_out_div = OUT_DIV_2;
        end
        MODE_X5: begin
          o_pll_in_div  = IN_DIV_4;
          o_pll_mult    = MULT_40;
          o_pll_out_div = OUT_DIV_2;
        end
        MODE_X10: begin
          o_pll_in_div  = IN_DIV_2;
          o_pll_mult    = MULT_40;
          o_pll_out_div = OUT_DIV_2;
        end
        MODE_X16: begin
          o_pll_in_div  = IN_DIV_2;
          o_pll_mult    = MULT_64;
          o_pll_out_div = OUT_DIV_2;
        end
        default: begin
          o_pll_in_div  = DIV_NONE;
        end
      endcase
    end
  end

  // avalon slave: every access answered on its second edge
  assign access            = (i_avs_read || i_avs_write) && !ack_ff;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_ff;
  assign wr_take           = i_avs_write && ack_ff;
  assign irq_clr = wr_take && i_avs_address == REG_IRQ
                   && i_avs_byteenable[0] && i_avs_writedata[IRQ_FLAG_BIT];

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_ff <= 1'b0;
    end else if (i_clk_en) begin
      ack_ff <= access;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sys_cfg_ff <= SYS_CFG_RST;
    end else if (i_clk_en) begin
      if (i_bidir_rst) begin
        sys_cfg_ff <= SYS_CFG_RST;
      end else if (wr_take && i_avs_address == REG_SYS_CFG) begin
        for (int b = 0; b < 4; b++) begin
          if (i_avs_byteenable[b]) begin
            sys_cfg_ff[b*8 +: 8] <= i_avs_writedata[b*8 +: 8];
          end
        end
      end
    end
  end

  // interrupt flag: a new failure wins over a clear in the same cycle;
  // the restart pulse still wins, as the source drops back to wait
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_ff <= 1'b0;
    end else if (i_clk_en) begin
      if (i_bidir_rst) begin
        irq_ff <= 1'b0;
      end else if (nxt_src == CCGOW_ST_FAILOVER
                   && src_ff != CCGOW_ST_FAILOVER) begin
        irq_ff <= 1'b1;
      end else if (irq_clr) begin
        irq_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_ff <= 32'h0000_0000;
    end else if (i_clk_en) begin
      if (i_avs_read && !ack_ff) begin
        rdata_ff <= 32'h0000_0000;
        case (i_avs_address)
          REG_SYS_CFG: rdata_ff <= sys_cfg_ff;
          REG_STATUS: begin
            rdata_ff[ST_MODE_LSB +: 3] <= mode_ff;
            rdata_ff[ST_FAIL_BIT]      <= wd_fail;
            rdata_ff[ST_ON_PLL_BIT]    <= src_ff == CCGOW_ST_FAILOVER;
            rdata_ff[ST_PLL_EN_BIT]    <= o_pll_enable;
            rdata_ff[ST_STRAP_BIT]     <= strap_ok_ff;
          end
          REG_IRQ: rdata_ff[IRQ_FLAG_BIT] <= irq_ff;
          default: rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign o_avs_readdata = rdata_ff;

endmodule : ccgow_top

// *** logic/ccgow_pkg.sv ***
package ccgow_pkg;

  // clock mode codes on the clock_mode_select_pins
  localparam logic [2:0] MODE_X16      = 3'h0;
  localparam logic [2:0] MODE_PRESCALE = 3'h1;
  localparam logic [2:0] MODE_X10      = 3'h2;
  localparam logic [2:0] MODE_DIRECT   = 3'h3;
  localparam logic [2:0] MODE_X5       = 3'h4;
  localparam logic [2:0] MODE_X8       = 3'h5;
  localparam logic [2:0] MODE_X3       = 3'h6;
  localparam logic [2:0] MODE_X4       = 3'h7;

  // multiplication factors
  localparam logic [4:0] FACT_X3  = 5'h03;
  localparam logic [4:0] FACT_X4  = 5'h04;
  localparam logic [4:0] FACT_X5  = 5'h05;
  localparam logic [4:0] FACT_X8  = 5'h08;
  localparam logic [4:0] FACT_X10 = 5'h0A;
  localparam logic [4:0] FACT_X16 = 5'h10;
  localparam logic [4:0] FACT_ONE = 5'h01;

  // pll divider chain settings
  localparam logic [6:0] IN_DIV_4  = 7'h04;
  localparam logic [6:0] IN_DIV_2  = 7'h02;
  localparam logic [6:0] MULT_64   = 7'h40;
  localparam logic [6:0] MULT_48   = 7'h30;
  localparam logic [6:0] MULT_40   = 7'h28;
  localparam logic [6:0] OUT_DIV_4 = 7'h04;
  localparam logic [6:0] OUT_DIV_2 = 7'h02;
  localparam logic [6:0] DIV_NONE  = 7'h00;

  // register word offsets
  localparam logic [1:0] REG_SYS_CFG = 2'h0;
  localparam logic [1:0] REG_STATUS  = 2'h1;
  localparam logic [1:0] REG_IRQ     = 2'h2;

  // field positions
  localparam int BIT_WD_DISABLE = 4;
  localparam int ST_MODE_LSB    = 0;
  localparam int ST_FAIL_BIT    = 3;
  localparam int ST_ON_PLL_BIT  = 4;
  localparam int ST_PLL_EN_BIT  = 5;
  localparam int ST_STRAP_BIT   = 6;
  localparam int IRQ_FLAG_BIT   = 0;

  localparam logic [31:0] SYS_CFG_RST = 32'h0000_0000;

  // watchdog overflow after this many free-running pll cycles
  localparam int OSC_WD_OVF = 16;

endpackage : ccgow_pkg

// *** logic/ccgow_osc_watchdog.sv ***
`timescale 1ns/1ns
module ccgow_osc_watchdog
  import ccgow_pkg::*;
#(
  parameter int CNT_W = 5,
  parameter int OVF   = OSC_WD_OVF
) (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst_b,
  input  wire logic i_clk_en,
  // control
  input  wire logic i_restart,
  input  wire logic i_enable,
  input  wire logic i_pll_tick,
  input  wire logic i_xtal_edge,
  // result
  output logic      o_fail
);

  logic [CNT_W-1:0] cnt_ff;
  logic             fail_ff;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(OVF - 1);

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_ff <= '0;
    end else if (i_clk_en) begin
      if (i_restart || !i_enable || i_xtal_edge || fail_ff) begin
        cnt_ff <= '0;
      end else if (i_pll_tick) begin
        cnt_ff <= cnt_ff + CNT_W'(1);
      end
    end
  end

  // once tripped, later counter activity is ignored until reset
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fail_ff <= 1'b0;
    end else if (i_clk_en) begin
      if (i_restart) begin
        fail_ff <= 1'b0;
      end else if (i_enable && !i_xtal_edge && i_pll_tick
                   && cnt_ff == LAST) begin
        fail_ff <= 1'b1;
      end
    end
  end

  assign o_fail = fail_ff;

endmodule : ccgow_osc_watchdog

// *** tb/ccgow_top_assertions.sv ***
`timescale 1ns/1ns
module ccgow_top_checker
  import ccgow_pkg::*;
#(
  parameter int FREE_DIV = 10
) (
  // clock and reset
  input wire logic       i_ref_clk,
  input wire logic       i_rst_b,
  input wire logic       i_bidir_rst,
  // watched ports
  input wire logic       i_crystal_input_pin,
  input wire logic       i_avs_read,
  input wire logic       i_avs_write,
  input wire logic       o_cpu_clk,
  input wire logic       o_pll_free_clk,
  input wire logic       o_pll_enable,
  input wire logic       o_osc_amp_bypass,
  input wire logic       o_osc_wd_irq,
  input wire logic [6:0] o_pll_in_div,
  input wire logic [6:0] o_pll_mult,
  input wire logic [6:0] o_pll_out_div,
  input wire logic       o_avs_waitrequest
);
  logic [2:0]  up_ff;
  logic        fail_ff;
  logic        xtal_ff;
  logic [15:0] quiet_ff;
  logic        settled;
  logic        on_xtal;

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  // cycles since strap; the bidirectional reset restarts it
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) up_ff <= 3'h0;
    else if (i_bidir_rst) up_ff <= 3'h0;
    else if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) fail_ff <= 1'b0;
    else if (i_bidir_rst) fail_ff <= 1'b0;
    else if (o_osc_wd_irq) fail_ff <= 1'b1;
  end
  // quiet time of the input, saturating so it never wraps
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      xtal_ff <= 1'b0;
      quiet_ff <= 16'h0000;
    end else begin
      xtal_ff <= i_crystal_input_pin;
      if (i_crystal_input_pin != xtal_ff) quiet_ff <= 16'h0000;
      else if (!(&quiet_ff)) quiet_ff <= quiet_ff + 16'h0001;
    end
  end
  assign settled = up_ff == 3'h7 && !i_bidir_rst;
  assign on_xtal = settled && !fail_ff && !o_osc_wd_irq;

  strap_hold_a: assert property (
    settled |-> $stable({o_pll_in_div, o_pll_mult, o_osc_amp_bypass}))
    else $error("mode outputs moved after strap");
  chain_48_a: assert property (
    o_pll_mult == MULT_48 |->
    o_pll_in_div == IN_DIV_4 && o_pll_out_div == OUT_DIV_4)
    else $error("divider chain wrong for x3");
  bypass_no_pll_a: assert property (
    o_osc_amp_bypass |-> o_pll_mult == DIV_NONE && o_pll_in_div == DIV_NONE)
    else $error("pll chain set in direct drive");
  pll_mode_on_a: assert property (
    o_pll_mult != DIV_NONE |-> o_pll_enable)
    else $error("pll off in multiply mode");
  free_off_a: assert property (
    (!o_pll_enable) [*3] |-> !o_pll_free_clk)
    else $error("free clock runs with pll off");
  wd_quiet_a: assert property (
    $rose(o_osc_wd_irq) |-> quiet_ff >= 16'(15 * 2 * FREE_DIV))
    else $error("watchdog fired too early");
  fail_hold_a: assert property (
    fail_ff && $past(fail_ff) && !i_bidir_rst |->
    o_cpu_clk == $past(o_pll_free_clk))
    else $error("cpu clock left the free clock");
  direct_copy_a: assert property (
    on_xtal && o_osc_amp_bypass |->
    o_cpu_clk == $past(i_crystal_input_pin, 2))
    else $error("direct clock not copied");
  prescale_tog_a: assert property (
    on_xtal && !o_osc_amp_bypass && o_pll_mult == DIV_NONE &&
    $rose(i_crystal_input_pin) |=>
    i_bidir_rst or ##2 (o_cpu_clk != $past(o_cpu_clk)))
    else $error("prescaled clock missed a toggle");
  wait_one_a: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus wait not one cycle");
endmodule : ccgow_top_checker

bind ccgow_top ccgow_top_checker #(.FREE_DIV(FREE_DIV)) chk_u (
  .i_ref_clk, .i_rst_b, .i_bidir_rst, .i_crystal_input_pin, .i_avs_read,
  .i_avs_write, .o_cpu_clk, .o_pll_free_clk, .o_pll_enable,
  .o_osc_amp_bypass, .o_osc_wd_irq, .o_pll_in_div, .o_pll_mult,
  .o_pll_out_div, .o_avs_waitrequest
);

// *** tb/ccgow_xtal_model.sv ***
`timescale 1ns/1ns
module ccgow_xtal_model (
  // clock and control
  input  wire logic       i_ref_clk,
  input  wire logic       i_run,
  input  wire logic [7:0] i_half,
  // crystal pin
  output logic            o_xtal
);
  logic [7:0] cnt_ff;

  initial begin
    o_xtal = 1'b0;
    cnt_ff = 8'h00;
  end
  // a dead crystal stops: the pin sticks at its last level
  always @(posedge i_ref_clk) begin
    if (i_run) begin
      if (cnt_ff + 8'h01 >= i_half) begin
        cnt_ff <= 8'h00;
        o_xtal <= ~o_xtal;
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end
endmodule : ccgow_xtal_model

// *** tb/cpu_clock_generator_osc_watchdog_test.sv ***
`timescale 1ns/1ns
module cpu_clock_generator_osc_watchdog_test
  import ccgow_pkg::*;
;
  localparam int FDIV = 2;
  logic        i_ref_clk;
  logic        i_rst_b;
  logic        i_clk_en;
  logic        i_bidir_rst;
  logic [2:0]  i_clock_mode_select_pins;
  logic        i_crystal_input_pin;
  logic        o_cpu_clk;
  logic        o_pll_free_clk;
  logic        o_pll_enable;
  logic        o_osc_amp_bypass;
  logic        o_osc_wd_irq;
  logic [6:0]  o_pll_in_div;
  logic [6:0]  o_pll_mult;
  logic [6:0]  o_pll_out_div;
  logic [1:0]  i_avs_address;
  logic        i_avs_read;
  logic        i_avs_write;
  logic [31:0] i_avs_writedata;
  logic [3:0]  i_avs_byteenable;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic        xtal_run;
  logic [7:0]  xtal_half;
  logic [31:0] rd_q[$];
  int          fails;
  int          total_checks;
  int          cyc;
  int          n;

  ccgow_top #(.FREE_DIV(FDIV)) dut_u (
    .i_ref_clk, .i_rst_b, .i_clk_en, .i_bidir_rst, .i_clock_mode_select_pins,
    .i_crystal_input_pin, .o_cpu_clk, .o_pll_free_clk, .o_pll_enable,
    .o_osc_amp_bypass, .o_osc_wd_irq, .o_pll_in_div, .o_pll_mult,
    .o_pll_out_div, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest
  );
  ccgow_xtal_model xtal_u (
    .i_ref_clk, .i_run(xtal_run), .i_half(xtal_half),
    .o_xtal(i_crystal_input_pin)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic bus(input logic [1:0] a, input logic w, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_avs_address <= a;
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_writedata <= d;
    @(posedge i_ref_clk);
    while (o_avs_waitrequest !== 1'b0) @(posedge i_ref_clk);
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [1:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(a, 1'b0, 32'h0000_0000);
  endtask : rd

  // pins change at random after the strap edge; they must not matter
  task automatic restart(input logic [2:0] m, input logic use_bidir);
    @(posedge i_ref_clk);
    i_clock_mode_select_pins <= m;
    i_rst_b <= use_bidir;
    i_bidir_rst <= use_bidir;
    @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    i_bidir_rst <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    i_clock_mode_select_pins <= 3'($urandom);
  endtask : restart

  task automatic toggles(output int t);
    logic p;
    p = o_cpu_clk;
    t = 0;
    repeat (60) begin
      @(posedge i_ref_clk);
      if (o_cpu_clk !== p) t++;
      p = o_cpu_clk;
    end
  endtask : toggles

  function automatic logic [31:0] divx(input logic [2:0] m);
    case (m)
      MODE_X4:  return {11'h000, IN_DIV_4, MULT_64, OUT_DIV_4};
      MODE_X3:  return {11'h000, IN_DIV_4, MULT_48, OUT_DIV_4};
      MODE_X8:  return {11'h000, IN_DIV_4, MULT_64, OUT_DIV_2};
      MODE_X5:  return {11'h000, IN_DIV_4, MULT_40, OUT_DIV_2};
      MODE_X10: return {11'h000, IN_DIV_2, MULT_40, OUT_DIV_2};
      MODE_X16: return {11'h000, IN_DIV_2, MULT_64, OUT_DIV_2};
      default:  return 32'h0000_0000;
    endcase
  endfunction : divx

  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 12000) begin
      fails++;
      wrap_up();
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_avs_read === 1'b1 && o_avs_waitrequest === 1'b0)
      chk(o_avs_readdata, rd_q.pop_front());
  end

  initial begin
    i_rst_b = 1'b0;
    i_clk_en = 1'b1;
    i_bidir_rst = 1'b0;
    i_clock_mode_select_pins = MODE_X4;
    i_avs_address = 2'h0;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_writedata = 32'h0000_0000;
    i_avs_byteenable = 4'hF;
    xtal_run = 1'b1;
    xtal_half = 8'h02;
    void'($urandom(91018));
    repeat (2) @(posedge i_ref_clk);
    for (int m = 0; m < 8; m++) begin
      restart(3'(m), m[0]);
      chk(32'({o_pll_in_div, o_pll_mult, o_pll_out_div}), divx(3'(m)));
      chk(32'(o_osc_amp_bypass), 32'(m == 3));
      chk(32'(o_pll_enable), 32'h1);
      rd(REG_STATUS, 32'h60 | 32'(m));
      if (m == 1 || m == 3) begin
        toggles(n);
        chk(32'(n > (m == 1 ? 13 : 28) && n < (m == 1 ? 17 : 32)), 32'h1);
      end
    end
    restart(MODE_DIRECT, 1'b0);
    wr(REG_SYS_CFG, 32'h10);
    rd(REG_SYS_CFG, 32'h10);
    repeat (4) @(posedge i_ref_clk);
    chk(32'(o_pll_enable), 32'h0);
    xtal_run <= 1'b0;
    repeat (150) @(posedge i_ref_clk);
    chk(32'(o_osc_wd_irq), 32'h0);
    xtal_run <= 1'b1;
    wr(REG_SYS_CFG, 32'h00);
    xtal_half <= 8'h1E;
    repeat (300) @(posedge i_ref_clk);
    chk(32'(o_osc_wd_irq), 32'h0);
    xtal_half <= 8'h02;
    for (int k = 0; k < 2; k++) begin
      restart(k == 0 ? MODE_PRESCALE : MODE_DIRECT, 1'(k));
      rd(REG_STATUS, k == 0 ? 32'h61 : 32'h63);
      rd(REG_SYS_CFG, 32'h00);
      xtal_run <= 1'b0;
      n = 0;
      while (o_osc_wd_irq !== 1'b1 && n < 200) begin
        @(posedge i_ref_clk);
        n++;
      end
      chk(32'(n >= 60 && n <= 80), 32'h1);
      xtal_run <= 1'b1;
      repeat (100) @(posedge i_ref_clk);
      wr(REG_SYS_CFG, 32'h10);
      rd(REG_STATUS, k == 0 ? 32'h79 : 32'h7B);
      chk(32'(o_pll_enable), 32'h1);
      rd(REG_IRQ, 32'h1);
      wr(REG_IRQ, 32'h1);
      rd(REG_IRQ, 32'h0);
      wr(2'h3, 32'hFFFF_FFFF);
      rd(2'h3, 32'h0000_0000);
    end
    restart(MODE_PRESCALE, 1'b1);
    rd(REG_STATUS, 32'h61);
    @(posedge i_ref_clk);
    chk(32'(rd_q.size()), 32'h0);
    wrap_up();
  end
endmodule : cpu_clock_generator_osc_watchdog_test
